// ---- logic/ldr_rx_deser.sv ----
// Serial receive lane deserializer with bypass, PLL clock tap and register port
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module ldr_rx_deser #(
  parameter int AW = 8
) (
  // System clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // Register bus write address, data and response
  input  wire logic [AW-1:0] awaddr,
  input  wire logic [2:0]    awprot,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // Register bus read
  input  wire logic [AW-1:0] araddr,
  input  wire logic [2:0]    arprot,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  // Link
  input  wire logic          serial_bit_clock,
  input  wire logic          parallel_word_clock,
  input  wire logic          rx_pad_pos,
  input  wire logic          rx_pad_neg,
  // Fabric side
  input  wire logic          rxDynamicEnable,
  output logic [7:0]         rxWord,
  output logic               rxWordValid,
  output logic               alternate_clock_out,
  // Analog controls
  output logic               rxBufferEnable,
  output logic               rxTermEnable,
  output logic [5:0]         rxDelayCode
);

  typedef struct packed {
    ldr_pkg::ldr_ch_e wrSt;
    ldr_pkg::ldr_ch_e rdSt;
    logic             awHeld;
    logic             wHeld;
    logic [AW-1:0]    awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic [1:0]       bResp;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic             deserEn;
    logic             connAlt;
    logic             odtEn;
    logic [3:0]       width;
    logic [5:0]       delay;
    logic             cfgTgl;
    logic             wordSeen;
    logic [7:0]       wordCap;
    logic [15:0]      wordCnt;
  } ldr_sys_s;

  typedef struct packed {
    logic             cfgSeen;
    logic             deserEn;
    logic             connAlt;
    logic [3:0]       width;
    logic             padBit;
    logic [7:0]       shift;
    logic             slowSeen;
    logic [7:0]       word;
    logic             wordTgl;
    logic             wordValid;
  } ldr_ser_s;

  ldr_sys_s   sq;
  ldr_sys_s   sd;
  ldr_ser_s   xq;
  ldr_ser_s   xd;
  logic [1:0] rstSysPipe;
  logic [1:0] rstSerPipe;
  logic       rstSysN;
  logic       rstSerN;
  logic [2:0] sysSync;
  logic [2:0] serSync;
  logic       wordTglSys;
  logic       cfgAckSys;
  logic       dynEnSys;
  logic       cfgTglSer;
  logic       slowSer;
  logic       dynEnSer;

  // Control word as seen by software
  function automatic logic [31:0] ctrlWord(input ldr_sys_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[ldr_pkg::CTRL_DESER_BIT] = s.deserEn;
    v[ldr_pkg::CTRL_ALT_BIT] = s.connAlt;
    v[ldr_pkg::CTRL_ODT_BIT] = s.odtEn;
    v[ldr_pkg::CTRL_WIDTH_LSB +: 4] = s.width;
    v[ldr_pkg::CTRL_DELAY_LSB +: 6] = s.delay;
    return v;
  endfunction

  // Byte lane merge of a write into an old value
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return v;
  endfunction

  // Reset release, two flip-flops per domain
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSysPipe <= 2'h0;
    end else begin
      rstSysPipe <= {rstSysPipe[0], 1'b1};
    end
  end
  assign rstSysN = rstSysPipe[1];

  always_ff @(posedge serial_bit_clock or negedge rstSysN) begin
    if (!rstSysN) begin
      rstSerPipe <= 2'h0;
    end else begin
      rstSerPipe <= {rstSerPipe[0], 1'b1};
    end
  end
  assign rstSerN = rstSerPipe[1];

  // Crossings into the system domain
  ldr_sync #(.W(3)) uSysSync (
    .clk  (sys_clk),
    .rstN (rstSysN),
    .din  ({xq.wordTgl, xq.cfgSeen, rxDynamicEnable}),
    .dout (sysSync)
  );
  assign {wordTglSys, cfgAckSys, dynEnSys} = sysSync;

  // Crossings into the link domain
  ldr_sync #(.W(3)) uSerSync (
    .clk  (serial_bit_clock),
    .rstN (rstSerN),
    .din  ({sq.cfgTgl, parallel_word_clock, rxDynamicEnable}),
    .dout (serSync)
  );
  assign {cfgTglSer, slowSer, dynEnSer} = serSync;

  // System domain: register slave and status capture
  always_comb begin
    logic        awNow;
    logic        wNow;
    logic [AW-1:0] wAddr;
    logic [31:0] wVal;
    logic [31:0] cVal;
    logic [31:0] sVal;
    awNow = sq.awHeld | (awvalid & awready);
    wNow  = sq.wHeld | (wvalid & wready);
    wAddr = sq.awHeld ? sq.awAddr : awaddr;
    wVal  = sq.wHeld ? sq.wData : wdata;
    cVal  = mergeBytes(ctrlWord(sq), wVal, sq.wHeld ? sq.wStrb : wstrb);
    sVal  = 32'h0000_0000;
    sVal[ldr_pkg::STAT_WORD_LSB +: 8] = sq.wordCap;
    sVal[ldr_pkg::STAT_BUFEN_BIT] = dynEnSys;
    sVal[ldr_pkg::STAT_BYPASS_BIT] = ~sq.deserEn;
    sVal[ldr_pkg::STAT_APPLIED_BIT] = (cfgAckSys == sq.cfgTgl);
    sVal[ldr_pkg::STAT_CNT_LSB +: 16] = sq.wordCnt;
    sd = sq;

    case (sq.wrSt)
      ldr_pkg::CH_IDLE: begin
        if (awNow && wNow) begin
          sd.awHeld = 1'b0;
          sd.wHeld  = 1'b0;
          sd.wrSt   = ldr_pkg::CH_RESP;
          sd.bResp  = ldr_pkg::RESP_OKAY;
          if (wAddr == AW'(ldr_pkg::CTRL_OFS)) begin
            sd.deserEn = cVal[ldr_pkg::CTRL_DESER_BIT];
            sd.connAlt = cVal[ldr_pkg::CTRL_ALT_BIT];
            sd.odtEn   = cVal[ldr_pkg::CTRL_ODT_BIT];
            sd.delay   = cVal[ldr_pkg::CTRL_DELAY_LSB +: 6];
            // Illegal widths leave the old width in place
            if (cVal[ldr_pkg::CTRL_WIDTH_LSB +: 4] >= ldr_pkg::WIDTH_MIN &&
                cVal[ldr_pkg::CTRL_WIDTH_LSB +: 4] <= ldr_pkg::WIDTH_MAX) begin
              sd.width = cVal[ldr_pkg::CTRL_WIDTH_LSB +: 4];
            end
            sd.cfgTgl = ~sq.cfgTgl;
          end else if (wAddr != AW'(ldr_pkg::STAT_OFS)) begin
            sd.bResp = ldr_pkg::RESP_SLVERR;
          end
        end else begin
          if (awvalid && awready) begin
            sd.awHeld = 1'b1;
            sd.awAddr = awaddr;
          end
          if (wvalid && wready) begin
            sd.wHeld = 1'b1;
            sd.wData = wdata;
            sd.wStrb = wstrb;
          end
        end
      end
      ldr_pkg::CH_RESP: begin
        if (bready) begin
          sd.wrSt = ldr_pkg::CH_IDLE;
        end
      end
      default: begin
        sd.wrSt = ldr_pkg::CH_IDLE;
      end
    endcase

    case (sq.rdSt)
      ldr_pkg::CH_IDLE: begin
        if (arvalid) begin
          sd.rdSt  = ldr_pkg::CH_RESP;
          sd.rResp = ldr_pkg::RESP_OKAY;
          if (araddr == AW'(ldr_pkg::CTRL_OFS)) begin
            sd.rData = ctrlWord(sq);
          end else if (araddr == AW'(ldr_pkg::STAT_OFS)) begin
            sd.rData = sVal;
          end else begin
            sd.rData = 32'h0000_0000;
            sd.rResp = ldr_pkg::RESP_SLVERR;
          end
        end
      end
      ldr_pkg::CH_RESP: begin
        if (rready) begin
          sd.rdSt = ldr_pkg::CH_IDLE;
        end
      end
      default: begin
        sd.rdSt = ldr_pkg::CH_IDLE;
      end
    endcase

    // Link word is held stable until its toggle has crossed, except in bypass with the clock tap off, where it follows the pad bit every bit clock
    if (wordTglSys != sq.wordSeen) begin
      sd.wordSeen = wordTglSys;
      sd.wordCap  = xq.word;
      sd.wordCnt  = sq.wordCnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSysN) begin
    if (!rstSysN) begin
      sq         <= '0;
      sq.wrSt    <= ldr_pkg::CH_IDLE;
      sq.rdSt    <= ldr_pkg::CH_IDLE;
      sq.deserEn <= ldr_pkg::RST_DESER;
      sq.connAlt <= ldr_pkg::RST_ALT;
      sq.odtEn   <= ldr_pkg::RST_ODT;
      sq.width   <= ldr_pkg::RST_WIDTH;
      sq.delay   <= ldr_pkg::RST_DELAY;
    end else begin
      sq <= sd;
    end
  end

  assign awready = (sq.wrSt == ldr_pkg::CH_IDLE) & ~sq.awHeld;
  assign wready  = (sq.wrSt == ldr_pkg::CH_IDLE) & ~sq.wHeld;
  assign bvalid  = (sq.wrSt == ldr_pkg::CH_RESP);
  assign bresp   = sq.bResp;
  assign arready = (sq.rdSt == ldr_pkg::CH_IDLE);
  assign rvalid  = (sq.rdSt == ldr_pkg::CH_RESP);
  assign rresp   = sq.rResp;
  assign rdata   = sq.rData;

  // Link domain: shift and word assembly
  always_comb begin
    logic [7:0] mask;
    logic       slowRise;
    mask     = 8'hFF >> (4'h8 - xq.width);
    slowRise = slowSer & ~xq.slowSeen;
    xd           = xq;
    xd.wordValid = 1'b0;
    xd.slowSeen  = slowSer;
    // Settings copied only once their toggle has crossed
    if (cfgTglSer != xq.cfgSeen) begin
      xd.cfgSeen = cfgTglSer;
      xd.deserEn = sq.deserEn;
      xd.connAlt = sq.connAlt;
      xd.width   = sq.width;
    end
    if (dynEnSer) begin
      // Equal pad levels are not a valid differential state; keep last bit
      if (rx_pad_pos != rx_pad_neg) begin
        xd.padBit = rx_pad_pos;
      end
      xd.shift = {xq.shift[6:0], xq.padBit};
    end
    if (xq.connAlt) begin
      xd.word = 8'h00;
    end else if (!xq.deserEn) begin
      xd.word = {7'h00, xq.padBit};
    end else if (slowRise) begin
      xd.word = xq.shift & mask;
    end
    if (slowRise && !xq.connAlt) begin
      xd.wordTgl   = ~xq.wordTgl;
      xd.wordValid = 1'b1;
    end
  end

  always_ff @(posedge serial_bit_clock or negedge rstSerN) begin
    if (!rstSerN) begin
      xq         <= '0;
      xq.deserEn <= ldr_pkg::RST_DESER;
      xq.connAlt <= ldr_pkg::RST_ALT;
      xq.width   <= ldr_pkg::RST_WIDTH;
    end else begin
      xq <= xd;
    end
  end

  assign rxWord      = xq.word;
  assign rxWordValid = xq.wordValid;
  // Clock path to the PLL stays unregistered to keep its edges
  assign alternate_clock_out = xq.connAlt & ~xq.deserEn & dynEnSer &
                               rx_pad_pos & ~rx_pad_neg;
  assign rxBufferEnable = dynEnSys;
  assign rxTermEnable   = sq.odtEn;
  assign rxDelayCode    = sq.delay;

endmodule

// ---- logic/ldr_pkg.sv ----
// Shared constants and types for the serial receive lane deserializer
package ldr_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STAT_OFS        = 8'h04;

  // Control register field positions
  localparam int         CTRL_DESER_BIT  = 0;
  localparam int         CTRL_ALT_BIT    = 1;
  localparam int         CTRL_ODT_BIT    = 2;
  localparam int         CTRL_WIDTH_LSB  = 4;
  localparam int         CTRL_DELAY_LSB  = 8;

  // Status register field positions
  localparam int         STAT_WORD_LSB   = 0;
  localparam int         STAT_BUFEN_BIT  = 8;
  localparam int         STAT_BYPASS_BIT = 9;
  localparam int         STAT_APPLIED_BIT = 10;
  localparam int         STAT_CNT_LSB    = 16;

  // Values after reset
  localparam logic       RST_DESER       = 1'b1;
  localparam logic       RST_ALT         = 1'b0;
  localparam logic       RST_ODT         = 1'b0;
  localparam logic [3:0] RST_WIDTH       = 4'h8;
  localparam logic [5:0] RST_DELAY       = 6'h00;

  // Legal deserialization widths
  localparam logic [3:0] WIDTH_MIN       = 4'h2;
  localparam logic [3:0] WIDTH_MAX       = 4'h8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // Link and analog figures
  localparam int         MAX_RATE_MBPS   = 800;
  localparam int         BIT_PERIOD_PS   = 1000000 / MAX_RATE_MBPS;
  localparam int         DELAY_STEP_PS   = 25;
  localparam int         ODT_OHMS        = 100;
  localparam int         SYS_CLK_MHZ     = 50;
  localparam int         SYS_PERIOD_NS   = 1000 / SYS_CLK_MHZ;

  // Bus channel states
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } ldr_ch_e;

endpackage

// ---- logic/ldr_sync.sv ----
// Three-stage synchronizer; a change is taken once stages two and three agree
`timescale 1ns/10ps
module ldr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ldr_sync_s;

  ldr_sync_s q;
  ldr_sync_s d;

  always_comb begin
    d     = q;
    d.s1  = din;
    d.s2  = q.s1;
    d.s3  = q.s2;
    // Hold the old level while the two late stages disagree
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.lvl;

endmodule

// ---- sim/ldr_rx_deser_sva.sv ----
// Port-level assertions for the receive lane deserializer
`timescale 1ns/10ps
module ldr_rx_deser_sva (
  // Clocks and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        serial_bit_clock,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Link and fabric
  input wire logic        rx_pad_pos,
  input wire logic        rx_pad_neg,
  input wire logic        rxWordValid,
  input wire logic        alternate_clock_out,
  input wire logic        rxDynamicEnable,
  input wire logic        rxBufferEnable
);
  a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped early");
  a_write_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    arvalid && arready |=> rvalid)
    else $error("read response late");
  a_write_refused: assert property (@(posedge sys_clk) disable iff (!resetn)
    bvalid |-> !awready && !wready && !$rose(awready))
    else $error("write taken while response pending");
  a_alt_tap: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    alternate_clock_out |-> rx_pad_pos && !rx_pad_neg)
    else $error("clock tap high without pad level");
  a_alt_no_word: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    alternate_clock_out |=> !rxWordValid)
    else $error("word valid while clock tap active");
  a_valid_pulse: assert property (
    @(posedge serial_bit_clock) disable iff (!resetn)
    rxWordValid |=> !rxWordValid [*4])
    else $error("word valid longer than one cycle");
  a_buffer_follow: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $changed(rxDynamicEnable) |-> ##[1:6] rxBufferEnable == rxDynamicEnable)
    else $error("buffer enable did not follow");
endmodule
bind ldr_rx_deser ldr_rx_deser_sva u_sva (
  .sys_clk             (sys_clk),
  .resetn              (resetn),
  .serial_bit_clock    (serial_bit_clock),
  .awvalid             (awvalid),
  .awready             (awready),
  .wvalid              (wvalid),
  .wready              (wready),
  .bvalid              (bvalid),
  .bready              (bready),
  .bresp               (bresp),
  .arvalid             (arvalid),
  .arready             (arready),
  .rvalid              (rvalid),
  .rready              (rready),
  .rdata               (rdata),
  .rx_pad_pos          (rx_pad_pos),
  .rx_pad_neg          (rx_pad_neg),
  .rxWordValid         (rxWordValid),
  .alternate_clock_out (alternate_clock_out),
  .rxDynamicEnable     (rxDynamicEnable),
  .rxBufferEnable      (rxBufferEnable)
);

// ---- sim/ldr_tx_model.sv ----
// Serial transmitter model driving the receive pads
`timescale 1ns/10ps
module ldr_tx_model (
  // Bench control
  input wire logic lineBit,
  // Link
  output logic     bitClk,
  output logic     wordClk,
  output logic     padPos,
  output logic     padNeg
);
  int cnt = 0;
  // Free running: the lane clock comes from a PLL, reset sync needs it
  initial begin
    bitClk = 1'b0;
    wordClk = 1'b0;
    padPos = 1'b0;
    padNeg = 1'b1;
    #1.7;
    forever #3 bitClk = ~bitClk;
  end
  // Pads move on the falling edge, away from the sampling edge
  always @(negedge bitClk) begin
    padPos <= lineBit;
    padNeg <= ~lineBit;
    cnt <= (cnt + 1) % 16;
    wordClk <= (cnt < 8);
  end
endmodule

// ---- sim/ldr_rx_deser_tb_top.sv ----
// Self-checking bench for the receive lane deserializer
`timescale 1ns/10ps
module ldr_rx_deser_tb_top;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, lineBit = 1'b0, enable = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, wordValid, altOut;
  logic        bufEn, termEn, bitClk, wordClk, padPos, padNeg;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0]  word, wv;
  logic [5:0]  delayCode;
  int          err_total = 0;
  int          checks = 0;
  int          ctrlM = 32'h81;
  int          lagSet = 32'h0000FFFF;
  int          hist[$];
  logic        lineHold = 1'b1;
  always #10 sys_clk = ~sys_clk;
  // Line frozen while a mode check reads it back
  always @(posedge sys_clk) begin
    if (!lineHold) lineBit <= 1'($urandom);
  end
  // Pad history, newest first; negedge avoids racing the word reader
  always @(negedge bitClk) begin
    hist.push_front(int'(padPos));
    if (hist.size() > 32) void'(hist.pop_back());
  end
  ldr_tx_model u_tx (.lineBit(lineBit), .bitClk(bitClk), .wordClk(wordClk),
    .padPos(padPos), .padNeg(padNeg));
  ldr_rx_deser u_dut (.sys_clk(sys_clk), .resetn(resetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .serial_bit_clock(bitClk),
    .parallel_word_clock(wordClk), .rx_pad_pos(padPos), .rx_pad_neg(padNeg),
    .rxDynamicEnable(enable), .rxWord(word), .rxWordValid(wordValid),
    .alternate_clock_out(altOut), .rxBufferEnable(bufEn),
    .rxTermEnable(termEn), .rxDelayCode(delayCode));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit awDone;
    bit wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic set_ctrl(input int de, input int al, input int od, input int wd, input int dl);
    int v;
    v = de | (al << 1) | (od << 2) | (wd << 4) | (dl << 8);
    bus_write(ldr_pkg::CTRL_OFS, 32'(v), rs);
    check("ctrl resp", 32'(rs), 32'h0);
    // Out of range width leaves the old width in place
    if (wd < 2 || wd > 8) v = (v & ~32'hF0) | (ctrlM & 32'hF0);
    ctrlM = v;
    repeat (40) @(posedge sys_clk);
    bus_read(ldr_pkg::CTRL_OFS, rd, rs);
    check("ctrl", rd, 32'(ctrlM));
    check("term", 32'(termEn), 32'(od));
    check("delay", 32'(delayCode), 32'(dl));
    bus_read(ldr_pkg::STAT_OFS, rd, rs);
    check("applied", 32'(rd[ldr_pkg::STAT_APPLIED_BIT]), 32'h1);
  endtask
  task automatic get_word(output logic [7:0] w);
    int n;
    n = 0;
    do begin
      @(posedge bitClk);
      n++;
    end while (wordValid !== 1'b1 && n < 200);
    w = word;
    if (n >= 200) check("word valid", 32'h0, 32'h1);
  endtask
  // Word model: n bits from l back in the history, earliest in the top bit
  function automatic int window(input int l, input int n);
    int v;
    v = 0;
    for (int j = 0; j < n; j++) begin
      v = v | (hist[l + j] << j);
    end
    return v;
  endfunction
  // Alignment is fixed, so a lag that fails one word is dropped for good
  task automatic model_word(input int n);
    int keep;
    keep = 0;
    get_word(wv);
    for (int l = 0; l < 16; l++) begin
      if (lagSet[l] && window(l, n) == int'(wv)) keep = keep | (1 << l);
    end
    lagSet = keep;
    check("word order", 32'(keep != 0), 32'h1);
    check("word width", 32'(wv) >> n, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
  initial begin
    void'($urandom(32'hCBF12B98));
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (30) @(posedge sys_clk);
    bus_read(ldr_pkg::CTRL_OFS, rd, rs);
    check("ctrl reset", rd, 32'h00000081);
    lineHold <= 1'b0;
    // Width 9 is refused, so the word stays eight bits wide
    for (int w = 2; w <= 9; w++) begin
      set_ctrl(1, 0, w % 2, w, $urandom % 64);
      repeat (3) model_word(ctrlM[7:4]);
      @(posedge sys_clk);
    end
    bus_read(8'h10, rd, rs);
    check("unmapped resp", 32'(rs), 32'h2);
    check("unmapped data", rd, 32'h0);
    bus_write(8'h20, 32'h0, rs);
    check("unmapped wr", 32'(rs), 32'h2);
    bus_write(ldr_pkg::STAT_OFS, 32'hFFFFFFFF, rs);
    check("stat wr", 32'(rs), 32'h0);
    bus_read(ldr_pkg::CTRL_OFS, rd, rs);
    check("ctrl kept", rd, 32'(ctrlM));
    // Modes: bypass, clock tap, and tap chosen while deserializing
    for (int m = 0; m < 3; m++) begin
      set_ctrl(m == 2, m > 0, 0, 8, 0);
      repeat (4) begin
        lineHold <= 1'b0;
        @(posedge sys_clk);
        lineHold <= 1'b1;
        repeat (10) @(posedge bitClk);
        check("tap", 32'(altOut), 32'((m == 1) & lineBit));
        if (m < 2) check("bypass word", 32'(word), m ? 32'h0 : 32'(lineBit));
      end
      @(posedge sys_clk);
      bus_read(ldr_pkg::STAT_OFS, rd, rs);
      check("stat bypass", 32'(rd[9]), 32'(m < 2));
    end
    for (int e = 0; e < 2; e++) begin
      enable <= 1'(e);
      repeat (20) @(posedge sys_clk);
      check("buffer en", 32'(bufEn), 32'(e));
      bus_read(ldr_pkg::STAT_OFS, rd, rs);
      check("stat buffer", 32'(rd[8]), 32'(e));
    end
    final_report();
  end
endmodule
